// ---- logic/esbi_top.sv ----
// Functional notes
// - with switch 1 on, power returns only after a reset closure with all enabled loops closed; off, reset is unused.
// - switch 2 on makes a high brake request activate its brake output, off makes a low one do so.
// - switch 3 on makes the logic output follow motor power, off holds it false.
// - switch 4 on opens the relay output while a stop event is active.
// - switch 5 on monitors the internal loop, which must be closed to clear a stop; off ignores it.
// - switch 6 on monitors the external loop, which must be closed to clear a stop; off ignores it.
// - switch 7 on reports under-voltage states, off reports none.
// - the led shows green, 4 green then dark, red, 2 green 2 red, 1 green 3 red or alternating for the board states.
// - the relay control input sets the relay contact state.
`timescale 1ns/100ps
module esbi_top
  import esbi_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [7:0] CONFIG_SWITCH_BANK,
  input wire logic INTERNAL_STOP_LOOP_POS,
  input wire logic INTERNAL_STOP_LOOP_NEG,
  input wire logic EXTERNAL_STOP_LOOP_POS,
  input wire logic EXTERNAL_STOP_LOOP_NEG,
  input wire logic MOTOR_RESET_CLOSED,
  input wire logic BRAKE_REQUEST_A,
  input wire logic BRAKE_REQUEST_B,
  input wire logic RELAY_CONTROL_IN,
  input wire logic MOTOR_SUPPLY_LOW,
  input wire logic SUPPLY_24V_LOW,
  input wire logic REGEN_LOCKED,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic MOTOR_POWER_EN,
  output logic BRAKE_OUTPUT_A,
  output logic BRAKE_OUTPUT_B,
  output logic MOTOR_POWER_STATE_OUT,
  output logic RELAY_CLOSED,
  output logic LED_GREEN,
  output logic LED_RED
);

  logic [PIN_W-1:0] pins_raw, sync1_q, pin_q;
  logic reset_prev_q;
  logic [1:0] fill_q;
  logic [7:0] sw;
  logic int_closed, ext_closed, loops_ok, rst_rise, estop_active;
  logic mpwr_low_rep, low24_rep;
  esbi_state_t state_q, state_d;
  esbi_led_code_t led_code_q, led_code_d;
  logic pwr_q, pwr_d, brk_a_q, brk_a_d, brk_b_q, brk_b_d;
  logic logic_out_q, logic_out_d, relay_q, relay_d;
  logic soft_stop_q, soft_stop_d;
  logic acc_q, acc_d, wr_q, wr_d;
  logic [3:0] addr_q, addr_d;
  logic [31:0] rdata_q, rdata_d;

  assign pins_raw = {REGEN_LOCKED, SUPPLY_24V_LOW, MOTOR_SUPPLY_LOW,
                     RELAY_CONTROL_IN, BRAKE_REQUEST_B, BRAKE_REQUEST_A,
                     MOTOR_RESET_CLOSED, EXTERNAL_STOP_LOOP_NEG,
                     EXTERNAL_STOP_LOOP_POS, INTERNAL_STOP_LOOP_NEG,
                     INTERNAL_STOP_LOOP_POS, CONFIG_SWITCH_BANK};

  // every pin crosses two flops before use
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sync1_q <= '0;
      pin_q <= '0;
      reset_prev_q <= 1'b0;
      fill_q <= 2'h0;
    end else begin
      sync1_q <= pins_raw;
      pin_q <= sync1_q;
      reset_prev_q <= pin_q[PIN_RESET];
      fill_q <= {fill_q[0], 1'b1};
    end
  end

  // sw[7] only reaches the status register: switch 8 is ignored
  assign sw = pin_q[PIN_SW +: 8];
  assign int_closed = pin_q[PIN_INT_POS] & ~pin_q[PIN_INT_NEG];
  assign ext_closed = pin_q[PIN_EXT_POS] & ~pin_q[PIN_EXT_NEG];
  // flushing synchroniser reads as all switches off: hold the stop
  assign loops_ok = (~sw[SW_INT_STOP] | int_closed)
                  & (~sw[SW_EXT_STOP] | ext_closed)
                  & ~soft_stop_q
                  & fill_q[1];
  // closure edge only; a held-closed reset cannot re-arm power
  assign rst_rise = pin_q[PIN_RESET] & ~reset_prev_q;
  assign mpwr_low_rep = sw[SW_UNDER_V] & pin_q[PIN_MPWR_LOW];
  assign low24_rep = sw[SW_UNDER_V] & pin_q[PIN_24V_LOW];
  assign estop_active = (state_q != ST_RUN);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_STOPPED: begin
        if (loops_ok) begin
          state_d = sw[SW_RESET_CFG] ? ST_WAIT_RESET : ST_RUN;
        end
      end
      ST_WAIT_RESET: begin
        if (!loops_ok) begin
          state_d = ST_STOPPED;
        end else if (rst_rise || !sw[SW_RESET_CFG]) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!loops_ok) begin
          state_d = ST_STOPPED;
        end
      end
      default: state_d = ST_STOPPED;
    endcase
    pwr_d = (state_q == ST_RUN);
    brk_a_d = sw[SW_BRAKE_POL] ? pin_q[PIN_BRK_A] : ~pin_q[PIN_BRK_A];
    brk_b_d = sw[SW_BRAKE_POL] ? pin_q[PIN_BRK_B] : ~pin_q[PIN_BRK_B];
    logic_out_d = sw[SW_LOGIC_OUT] & (state_q == ST_RUN);
    relay_d = pin_q[PIN_RELAY]
            & ~(sw[SW_RELAY_OUT] & estop_active);
    // stop states outrank supply faults on the led
    if (state_q == ST_STOPPED) begin
      led_code_d = LED_ESTOP_OPEN;
    end else if (state_q == ST_WAIT_RESET) begin
      led_code_d = LED_WAIT;
    end else if (pin_q[PIN_REGEN]) begin
      led_code_d = LED_REGEN;
    end else if (low24_rep) begin
      led_code_d = LED_24V_LOW;
    end else if (mpwr_low_rep) begin
      led_code_d = LED_MPWR_LOW;
    end else begin
      led_code_d = LED_OK;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_q <= ST_STOPPED;
      led_code_q <= LED_ESTOP_OPEN;
      pwr_q <= 1'b0;
      brk_a_q <= 1'b0;
      brk_b_q <= 1'b0;
      logic_out_q <= 1'b0;
      relay_q <= 1'b0;
    end else begin
      state_q <= state_d;
      led_code_q <= led_code_d;
      pwr_q <= pwr_d;
      brk_a_q <= brk_a_d;
      brk_b_q <= brk_b_d;
      logic_out_q <= logic_out_d;
      relay_q <= relay_d;
    end
  end

  // zero wait state slave; read data staged in the address phase
  always_comb begin
    acc_d = HSEL & HTRANS[1] & HREADY;
    wr_d = acc_d ? HWRITE : wr_q;
    addr_d = acc_d ? HADDR[3:0] : addr_q;
    soft_stop_d = soft_stop_q;
    if (acc_q && wr_q && addr_q == CTRL_OFS) begin
      soft_stop_d = HWDATA[CTRL_SOFT_STOP];
    end
    rdata_d = 32'h0000_0000;
    if (acc_d && !HWRITE) begin
      unique case (HADDR[3:0])
        STATUS_OFS: rdata_d = {16'h0000, sw, pin_q[PIN_REGEN], low24_rep,
                               mpwr_low_rep, estop_active, ext_closed,
                               int_closed, state_q};
        CTRL_OFS: rdata_d = {31'h0000_0000, soft_stop_d};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      acc_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 4'h0;
      soft_stop_q <= CTRL_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      acc_q <= acc_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      soft_stop_q <= soft_stop_d;
      rdata_q <= rdata_d;
    end
  end

  esbi_led_pattern #(
    .SLOT_LEN(SLOT_LEN)
  ) u_led (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .code(led_code_q),
    .led_green(LED_GREEN),
    .led_red(LED_RED)
  );

  assign HRDATA = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign MOTOR_POWER_EN = pwr_q;
  assign BRAKE_OUTPUT_A = brk_a_q;
  assign BRAKE_OUTPUT_B = brk_b_q;
  assign MOTOR_POWER_STATE_OUT = logic_out_q;
  assign RELAY_CLOSED = relay_q;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  a_reset_arms_run: assert property (
    (state_q != ST_RUN && state_d == ST_RUN && sw[SW_RESET_CFG])
      |-> (state_q == ST_WAIT_RESET && rst_rise && loops_ok))
    else $error("power armed without reset closure");
  a_sync_warmup: assert property (
    !fill_q[1] |=> state_q == ST_STOPPED)
    else $error("stop left before inputs settled");
  a_brake_polarity: assert property (
    RST_N |=> BRAKE_OUTPUT_A == ($past(sw[SW_BRAKE_POL])
      ? $past(pin_q[PIN_BRK_A]) : !$past(pin_q[PIN_BRK_A])))
    else $error("brake output polarity wrong");
  a_logic_out: assert property (
    1'b1 |=> MOTOR_POWER_STATE_OUT ==
      ($past(sw[SW_LOGIC_OUT]) && $past(state_q) == ST_RUN))
    else $error("logic output does not follow power");
  a_relay_opens: assert property (
    (sw[SW_RELAY_OUT] && estop_active) |=> !RELAY_CLOSED)
    else $error("relay closed during stop event");
  a_int_loop_stop: assert property (
    (sw[SW_INT_STOP] && !int_closed) |=> state_q == ST_STOPPED)
    else $error("open internal loop not latched");
  a_ext_loop_stop: assert property (
    (sw[SW_EXT_STOP] && !ext_closed) |=> state_q == ST_STOPPED)
    else $error("open external loop not latched");
  a_uv_masked: assert property (
    !sw[SW_UNDER_V] |-> (led_code_d != LED_24V_LOW
      && led_code_d != LED_MPWR_LOW))
    else $error("under-voltage reported while disabled");
  a_led_open_code: assert property (
    state_q == ST_STOPPED |=> led_code_q == LED_ESTOP_OPEN)
    else $error("open loop not shown on led");
  a_relay_follow: assert property (
    !sw[SW_RELAY_OUT] |=> RELAY_CLOSED == $past(pin_q[PIN_RELAY]))
    else $error("relay does not follow control input");
  a_power_held: assert property (
    state_q != ST_RUN |=> !MOTOR_POWER_EN)
    else $error("motor power on outside run");

endmodule

// ---- include/esbi_pkg.sv ----
package esbi_pkg;

  localparam int CORE_CLK_MHZ = 125;
  // led blink slot length
  localparam int SLOT_TIME_MS = 250;
  localparam int SLOT_CYCLES = SLOT_TIME_MS * 1000 * CORE_CLK_MHZ;
  localparam int SLOT_CNT_W = 32;
  localparam int SLOTS_PER_CODE = 8;

  // config switch bank bit positions
  localparam int SW_RESET_CFG = 0;
  localparam int SW_BRAKE_POL = 1;
  localparam int SW_LOGIC_OUT = 2;
  localparam int SW_RELAY_OUT = 3;
  localparam int SW_INT_STOP = 4;
  localparam int SW_EXT_STOP = 5;
  localparam int SW_UNDER_V = 6;

  // synchronised pin vector layout
  localparam int PIN_W = 19;
  localparam int PIN_SW = 0;
  localparam int PIN_INT_POS = 8;
  localparam int PIN_INT_NEG = 9;
  localparam int PIN_EXT_POS = 10;
  localparam int PIN_EXT_NEG = 11;
  localparam int PIN_RESET = 12;
  localparam int PIN_BRK_A = 13;
  localparam int PIN_BRK_B = 14;
  localparam int PIN_RELAY = 15;
  localparam int PIN_MPWR_LOW = 16;
  localparam int PIN_24V_LOW = 17;
  localparam int PIN_REGEN = 18;

  // register map, byte addresses
  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] CTRL_OFS = 4'h4;
  localparam int CTRL_SOFT_STOP = 0;
  localparam logic CTRL_RESET = 1'b0;

  typedef enum logic [1:0] {
    ST_STOPPED,
    ST_WAIT_RESET,
    ST_RUN
  } esbi_state_t;

  typedef enum logic [2:0] {
    LED_OK,
    LED_WAIT,
    LED_MPWR_LOW,
    LED_24V_LOW,
    LED_REGEN,
    LED_ESTOP_OPEN
  } esbi_led_code_t;

  // per-slot masks, slot 0 in bit 0
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_WAIT_G = 8'h0F;
  localparam logic [7:0] MASK_2G = 8'h05;
  localparam logic [7:0] MASK_2R = 8'h50;
  localparam logic [7:0] MASK_1G = 8'h01;
  localparam logic [7:0] MASK_3R = 8'h54;
  localparam logic [7:0] MASK_ALT_G = 8'h55;
  localparam logic [7:0] MASK_ALT_R = 8'hAA;

endpackage

// ---- logic/esbi_led_pattern.sv ----
`timescale 1ns/100ps
module esbi_led_pattern
  import esbi_pkg::*;
#(
  parameter int SLOT_LEN = SLOT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire esbi_led_code_t code,
  output logic led_green,
  output logic led_red
);

  logic [SLOT_CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0] slot_q, slot_d;
  esbi_led_code_t last_q;
  logic green_q, green_d, red_q, red_d;
  logic [7:0] gmask, rmask;

  always_comb begin
    gmask = MASK_NONE;
    rmask = MASK_NONE;
    unique case (code)
      LED_OK: gmask = MASK_ALL;
      LED_WAIT: gmask = MASK_WAIT_G;
      LED_MPWR_LOW: rmask = MASK_ALL;
      LED_24V_LOW: begin
        gmask = MASK_2G;
        rmask = MASK_2R;
      end
      LED_REGEN: begin
        gmask = MASK_1G;
        rmask = MASK_3R;
      end
      LED_ESTOP_OPEN: begin
        gmask = MASK_ALT_G;
        rmask = MASK_ALT_R;
      end
      default: gmask = MASK_NONE;
    endcase
    // restart the sequence on a new code so blinks count cleanly
    if (code != last_q) begin
      cnt_d = '0;
      slot_d = '0;
    end else if (cnt_q == SLOT_CNT_W'(SLOT_LEN - 1)) begin
      cnt_d = '0;
      slot_d = slot_q + 3'h1;
    end else begin
      cnt_d = cnt_q + SLOT_CNT_W'(1);
      slot_d = slot_q;
    end
    green_d = gmask[slot_d];
    red_d = rmask[slot_d];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      slot_q <= '0;
      last_q <= LED_OK;
      green_q <= 1'b0;
      red_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      slot_q <= slot_d;
      last_q <= code;
      green_q <= green_d;
      red_q <= red_d;
    end
  end

  assign led_green = green_q;
  assign led_red = red_q;

endmodule

// ---- tb/esbi_drive_model.sv ----
`timescale 1ns/100ps
module esbi_drive_model (
  input wire logic int_open,
  input wire logic ext_open,
  input wire logic brk_a,
  input wire logic brk_b,
  output logic int_pos,
  output logic int_neg,
  output logic ext_pos,
  output logic ext_neg,
  output logic req_a,
  output logic req_b
);
  // open loop inverts both legs, so no stale level survives
  assign int_pos = !int_open;
  assign int_neg = int_open;
  assign ext_pos = !ext_open;
  assign ext_neg = ext_open;
  assign req_a = brk_a;
  assign req_b = brk_b;
endmodule

// ---- tb/tb_estop_brake_interlock.sv ----
`timescale 1ns/100ps
module tb_estop_brake_interlock
  import esbi_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sw = 8'hFF;
  logic int_open = 1'b0;
  logic ext_open = 1'b0;
  logic brk_a = 1'b0;
  logic brk_b = 1'b0;
  logic rbtn = 1'b0;
  logic relay_in = 1'b1;
  logic mlow = 1'b0;
  logic vlow = 1'b0;
  logic regen = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hrdy, hresp, pwr, boa, bob, lout, relay, led_g, led_r;
  logic ip, ineg, ep, eneg, ra, rb;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #4 clk = ~clk;

  esbi_drive_model drv (.int_open(int_open), .ext_open(ext_open),
    .brk_a(brk_a), .brk_b(brk_b), .int_pos(ip), .int_neg(ineg),
    .ext_pos(ep), .ext_neg(eneg), .req_a(ra), .req_b(rb));

  esbi_top #(.SLOT_LEN(4)) dut (.CORE_CLK(clk), .RST_N(rst_n),
    .CONFIG_SWITCH_BANK(sw), .INTERNAL_STOP_LOOP_POS(ip),
    .INTERNAL_STOP_LOOP_NEG(ineg), .EXTERNAL_STOP_LOOP_POS(ep),
    .EXTERNAL_STOP_LOOP_NEG(eneg), .MOTOR_RESET_CLOSED(rbtn),
    .BRAKE_REQUEST_A(ra), .BRAKE_REQUEST_B(rb),
    .RELAY_CONTROL_IN(relay_in), .MOTOR_SUPPLY_LOW(mlow),
    .SUPPLY_24V_LOW(vlow), .REGEN_LOCKED(regen), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
    .HRESP(hresp), .MOTOR_POWER_EN(pwr), .BRAKE_OUTPUT_A(boa),
    .BRAKE_OUTPUT_B(bob), .MOTOR_POWER_STATE_OUT(lout),
    .RELAY_CLOSED(relay), .LED_GREEN(led_g), .LED_RED(led_r));

  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // whole run needs about 500 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic ahb(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {28'h0000000, a};
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic state_is(input logic [1:0] e);
    ahb(1'b0, STATUS_OFS, 32'h0);
    chk("state", {30'h0, e}, {30'h0, rd[1:0]});
  endtask

  // one code period is 8 slots of 4 cycles
  task automatic led(input int g, input int r);
    int ng;
    int nr;
    ng = 0;
    nr = 0;
    repeat (32) begin
      @(posedge clk);
      if (led_g === 1'b1) ng++;
      if (led_r === 1'b1) nr++;
    end
    chk("led_green", g, ng);
    chk("led_red", r, nr);
  endtask

  task automatic pulse();
    rbtn <= 1'b1;
    wt(4);
    rbtn <= 1'b0;
    wt(8);
  endtask

  initial begin
    wt(20);
    rst_n <= 1'b1;
    wt(8);
    state_is(2'h1);
    chk("power", 0, pwr);
    chk("relay", 0, relay);
    led(16, 0);
    pulse();
    chk("power", 1, pwr);
    chk("logic_out", 1, lout);
    chk("relay", 1, relay);
    led(32, 0);
    for (int p = 0; p < 2; p++) begin
      for (int q = 0; q < 4; q++) begin
        sw[1] <= p[0];
        sw[7] <= q[1];
        brk_a <= q[0];
        brk_b <= q[1];
        wt(6);
        chk("brake_a", q[0] == p[0], boa);
        chk("brake_b", q[1] == p[0], bob);
        chk("power", 1, pwr);
      end
    end
    sw[2] <= 1'b0;
    relay_in <= 1'b0;
    wt(6);
    chk("logic_out", 0, lout);
    chk("relay", 0, relay);
    sw[2] <= 1'b1;
    relay_in <= 1'b1;
    vlow <= 1'b1;
    wt(8);
    ahb(1'b0, STATUS_OFS, 32'h0);
    chk("v24_rep", 1, rd[6]);
    led(8, 8);
    sw[6] <= 1'b0;
    wt(8);
    ahb(1'b0, STATUS_OFS, 32'h0);
    chk("v24_rep", 0, rd[6]);
    vlow <= 1'b0;
    regen <= 1'b1;
    wt(8);
    led(4, 12);
    regen <= 1'b0;
    mlow <= 1'b1;
    sw[6] <= 1'b1;
    wt(8);
    led(0, 32);
    mlow <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      sw[4 + k] <= 1'b0;
      if (k == 0) int_open <= 1'b1;
      else ext_open <= 1'b1;
      wt(8);
      chk("power", 1, pwr);
      sw[4 + k] <= 1'b1;
      wt(8);
      chk("power", 0, pwr);
      chk("relay", 0, relay);
      led(16, 16);
      pulse();
      chk("power", 0, pwr);
      int_open <= 1'b0;
      ext_open <= 1'b0;
      wt(8);
      chk("power", 0, pwr);
      pulse();
      chk("power", 1, pwr);
    end
    // soft stop acts like an open loop
    ahb(1'b1, CTRL_OFS, 32'h1);
    wt(6);
    chk("power", 0, pwr);
    ahb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl", 32'h1, rd);
    ahb(1'b0, 4'h8, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 0, hresp);
    chk("hready", 1, hrdy);
    ahb(1'b1, CTRL_OFS, 32'h0);
    sw[0] <= 1'b0;
    wt(8);
    chk("power", 1, pwr);
    sw[3] <= 1'b0;
    int_open <= 1'b1;
    wt(8);
    chk("power", 0, pwr);
    chk("relay", 1, relay);
    stop_test();
  end
endmodule
